// ==== cfsl_regs.vh ====
// Purpose: constants of the CAN frame signalling logic
// Assumes: one bit_tick per bit time at the sample point
// Notes: levels are bus levels, 1 is recessive and 0 is dominant
//
// Summary of operation
// RULE1 - Remote frame: recessive RTR, no data, DLC ignored
// RULE2 - Remote DLC should match the data frame
// RULE3 - Error-active: six dominant bits as error flag
// RULE4 - Error-passive: recessive flag until six equal bits
// RULE5 - Flag violation makes others flag; six to twelve
// RULE6 - Wait recessive, then finish eight-bit delimiter
// RULE7 - New transmission only after delimiter and intermission
// RULE8 - Error while transmitting discards frame, schedules retry
// RULE9 - Any error frame deviation starts new error frame
// RULE10 - Overload only after intermission dominant, one bit later
// RULE11 - At most two overload frames per frame
// RULE12 - Overload frame never triggers retransmission
// RULE13 - Overload: six dominant, wait, seven recessive more
// RULE14 - Data frames need spacing; error/overload frames do not
// RULE15 - Intermission is three recessive bits, no starts
// RULE16 - Start only in idle; dominant there means SOF
// RULE17 - Recessive sent, dominant seen: drop to receiver
// RULE18 - Identifier MSB first, RTR last; lowest wins
// RULE19 - Identifiers with top eight bits ones forbidden
// RULE20 - Transmitter stuffs after five equal bits
// RULE21 - Receiver drops stuff bit, checks its polarity
// RULE22 - Fixed fields unstuffed, NRZ level per bit
// RULE23 - Identifier is 11 bits, sent bit 10 down
// RULE24 - Flag next bit; CRC error after ACK delimiter
// RULE25 - Flag type follows error-confinement input
`ifndef CFSL_REGS_VH
`define CFSL_REGS_VH

`define CFSL_RECESSIVE 1'h1
`define CFSL_DOMINANT 1'h0
`define CFSL_STUFF_RUN 3'h5
`define CFSL_FLAG_BITS 7'h06
`define CFSL_DELIM_BITS 7'h08
`define CFSL_EOF_BITS 7'h07
`define CFSL_INTER_BITS 7'h03
`define CFSL_SUSP_BITS 7'h08
`define CFSL_MAX_OVL 2'h2
`define CFSL_ID_BITS 11
`define CFSL_POS_RTR 7'h0c
`define CFSL_POS_DLC 7'h0f
`define CFSL_HDR_BITS 7'h13
`define CFSL_HDR_CRC_BITS 7'h22
`define CFSL_MAX_DATA 7'h40
`define CFSL_MAX_DLC 4'h8

`define CFSL_ERR_NONE 3'h0
`define CFSL_ERR_BIT 3'h1
`define CFSL_ERR_STUFF 3'h2
`define CFSL_ERR_FORM 3'h3
`define CFSL_ERR_ACK 3'h4
`define CFSL_ERR_CRC 3'h5

`endif

// ==== cfsl_frame.v ====
// Purpose: bit-level frame signalling of a CAN controller
// Assumes: bit_tick comes from bit timing logic on the same clock
// Notes: CRC value and check come from a separate CRC unit
`timescale 1ns/100ps
`default_nettype none
`include "cfsl_regs.vh"

module cfsl_frame (
	input wire clock,
	input wire rstn,
	input wire bit_tick,
	input wire can_rx,
	output reg can_tx,
	input wire err_passive,
	input wire tx_req,
	input wire [10:0] tx_id,
	input wire tx_rtr,
	input wire [3:0] tx_dlc,
	input wire [63:0] tx_data,
	input wire [14:0] tx_crc,
	input wire crc_bad,
	output reg tx_done,
	output reg tx_retry,
	output reg arb_lost,
	output reg rx_valid,
	output reg [10:0] rx_id,
	output reg rx_rtr,
	output reg [3:0] rx_dlc,
	output reg [63:0] rx_data,
	output reg dbit,
	output reg dbit_en,
	output reg hard_sync,
	output reg err_evt,
	output reg [2:0] err_code,
	output reg ovl_evt,
	output wire bus_idle
);

localparam [3:0] ST_IDLE = 4'h0;
localparam [3:0] ST_BODY = 4'h1;
localparam [3:0] ST_CRCD = 4'h2;
localparam [3:0] ST_ACKS = 4'h3;
localparam [3:0] ST_ACKD = 4'h4;
localparam [3:0] ST_EOF = 4'h5;
localparam [3:0] ST_INTER = 4'h6;
localparam [3:0] ST_SUSP = 4'h7;
localparam [3:0] ST_EFLAG = 4'h8;
localparam [3:0] ST_WAIT = 4'h9;
localparam [3:0] ST_DELIM = 4'ha;
localparam [3:0] ST_OFLAG = 4'hb;

reg rx_meta_q;
reg rx_s_q;
reg [3:0] st_q;
reg [6:0] cnt_q;
reg [6:0] pos_q;
reg [2:0] same_q;
reg last_q;
reg xmit_q;
reg pend_q;
reg susp_q;
reg fl_pas_q;
reg [1:0] ovl_q;

reg [2:0] err_c;
reg stuff_now;
reg lose_c;
reg [6:0] pos_n;
reg [2:0] same_n;
reg body_end;
reg body_tx;
reg [6:0] cnt_n;

// Destuffed data length; a remote frame has none whatever its DLC
function [6:0] data_len;
	input rtr;
	input [3:0] dlc;
	begin
		if (rtr) begin
			data_len = 7'h00; // [RULE1]
		end else if (dlc > `CFSL_MAX_DLC) begin
			data_len = `CFSL_MAX_DATA;
		end else begin
			data_len = {dlc, 3'h0};
		end
	end
endfunction

// Level of destuffed frame bit p of the pending message
function frame_bit;
	input [6:0] p;
	input [6:0] dl;
	reg [6:0] k;
	begin
		k = p - `CFSL_HDR_BITS;
		if (p == 7'h00) begin
			frame_bit = `CFSL_DOMINANT;
		end else if (p < `CFSL_POS_RTR) begin
			frame_bit = tx_id[4'hb - p[3:0]]; // [RULE23] [RULE18]
		end else if (p == `CFSL_POS_RTR) begin
			frame_bit = tx_rtr; // [RULE18] [RULE1]
		end else if (p < `CFSL_POS_DLC) begin
			frame_bit = `CFSL_DOMINANT;
		end else if (p < `CFSL_HDR_BITS) begin
			frame_bit = tx_dlc[2'h2 - p[1:0]];
		end else if (k < dl) begin
			frame_bit = tx_data[6'h3f - k[5:0]];
		end else begin
			k = k - dl;
			frame_bit = tx_crc[4'he - k[3:0]];
		end
	end
endfunction

assign bus_idle = (st_q == ST_IDLE);

////////////////////////////////////////////////////////////////////////
// Pin synchroniser; only rx_s_q is used by the frame logic
always @(posedge clock or negedge rstn) begin
	if (!rstn) begin
		rx_meta_q <= `CFSL_RECESSIVE;
		rx_s_q <= `CFSL_RECESSIVE;
	end else begin
		rx_meta_q <= can_rx;
		rx_s_q <= rx_meta_q;
	end
end

////////////////////////////////////////////////////////////////////////
// Error detection and stuffing arithmetic for the bit just sampled
always @* begin
	err_c = `CFSL_ERR_NONE;
	stuff_now = (st_q == ST_BODY) && (same_q == `CFSL_STUFF_RUN);
	lose_c = (st_q == ST_BODY) && xmit_q && !stuff_now && (pos_q != 7'h00)
		&& (pos_q <= `CFSL_POS_RTR) && can_tx && !rx_s_q; // [RULE17]
	pos_n = stuff_now ? pos_q : pos_q + 7'h01; // [RULE21]
	if (stuff_now || (rx_s_q != last_q)) begin
		same_n = 3'h1;
	end else begin
		same_n = same_q + 3'h1;
	end
	body_end = (pos_n == (`CFSL_HDR_CRC_BITS + data_len(rx_rtr, rx_dlc)))
		&& (same_n != `CFSL_STUFF_RUN);
	// A run of five forces the complement next, else the frame bit
	if (same_n == `CFSL_STUFF_RUN) begin
		body_tx = ~rx_s_q; // [RULE20]
	end else begin
		body_tx = frame_bit(pos_n, data_len(tx_rtr, tx_dlc));
	end
	// Passive flags count equal bits, active flags count sent bits
	if (fl_pas_q && (cnt_q != 7'h00) && (rx_s_q != last_q)) begin
		cnt_n = 7'h01; // [RULE4]
	end else begin
		cnt_n = cnt_q + 7'h01;
	end
	case (st_q)
	ST_BODY: begin
		if (stuff_now && (rx_s_q == last_q)) begin
			err_c = `CFSL_ERR_STUFF; // [RULE21] [RULE5]
		end else if (xmit_q && (rx_s_q != can_tx) && !lose_c) begin
			err_c = `CFSL_ERR_BIT;
		end
	end
	ST_CRCD, ST_ACKD, ST_EOF, ST_DELIM: begin
		if (!rx_s_q) begin
			err_c = `CFSL_ERR_FORM; // [RULE22] [RULE9] [RULE5]
		end else if ((st_q == ST_ACKD) && !xmit_q && crc_bad) begin
			err_c = `CFSL_ERR_CRC; // [RULE24]
		end
	end
	ST_ACKS: begin
		if (xmit_q && rx_s_q) begin
			err_c = `CFSL_ERR_ACK;
		end
	end
	ST_EFLAG: begin
		if (!fl_pas_q && rx_s_q) begin
			err_c = `CFSL_ERR_BIT; // [RULE9]
		end
	end
	ST_OFLAG: begin
		if (rx_s_q) begin
			err_c = `CFSL_ERR_BIT; // [RULE9]
		end
	end
	default: begin
		err_c = `CFSL_ERR_NONE;
	end
	endcase
end

////////////////////////////////////////////////////////////////////////
// Frame sequencer; all bus decisions are taken on bit_tick
always @(posedge clock or negedge rstn) begin
	if (!rstn) begin
		st_q <= ST_IDLE;
		cnt_q <= 7'h00;
		pos_q <= 7'h00;
		same_q <= 3'h0;
		last_q <= `CFSL_RECESSIVE;
		xmit_q <= 1'h0;
		pend_q <= 1'h0;
		susp_q <= 1'h0;
		fl_pas_q <= 1'h0;
		ovl_q <= 2'h0;
		can_tx <= `CFSL_RECESSIVE;
		tx_done <= 1'h0;
		tx_retry <= 1'h0;
		arb_lost <= 1'h0;
		rx_valid <= 1'h0;
		rx_id <= 11'h000;
		rx_rtr <= 1'h0;
		rx_dlc <= 4'h0;
		rx_data <= 64'h0;
		dbit <= 1'h0;
		dbit_en <= 1'h0;
		hard_sync <= 1'h0;
		err_evt <= 1'h0;
		err_code <= `CFSL_ERR_NONE;
		ovl_evt <= 1'h0;
	end else begin
		tx_done <= 1'h0;
		tx_retry <= 1'h0;
		arb_lost <= 1'h0;
		rx_valid <= 1'h0;
		dbit_en <= 1'h0;
		hard_sync <= 1'h0;
		err_evt <= 1'h0;
		ovl_evt <= 1'h0;
		// A request in the same cycle as completion stays pending
		if (tx_req) begin
			pend_q <= 1'h1;
		end
		if (bit_tick && (err_c != `CFSL_ERR_NONE)) begin
			// Flag goes out on the very next bit, no inter-frame space
			st_q <= ST_EFLAG; // [RULE24] [RULE14]
			cnt_q <= 7'h00;
			fl_pas_q <= err_passive; // [RULE25]
			can_tx <= err_passive ? `CFSL_RECESSIVE : `CFSL_DOMINANT; // [RULE3] [RULE4]
			last_q <= rx_s_q;
			err_evt <= 1'h1;
			err_code <= err_c;
			if (xmit_q) begin
				xmit_q <= 1'h0; // [RULE8]
				tx_retry <= 1'h1; // [RULE8]
				susp_q <= 1'h1;
			end
		end else if (bit_tick) begin
			case (st_q)
			ST_IDLE, ST_SUSP: begin
				cnt_q <= cnt_q + 7'h01;
				if (!rx_s_q) begin
					// Someone else's start of frame: join as receiver
					st_q <= ST_BODY; // [RULE16]
					pos_q <= 7'h01;
					same_q <= 3'h1;
					last_q <= `CFSL_DOMINANT;
					hard_sync <= 1'h1; // [RULE16]
					ovl_q <= 2'h0;
					susp_q <= 1'h0;
				end else if ((st_q == ST_SUSP) && (cnt_q == `CFSL_SUSP_BITS - 7'h01)) begin
					st_q <= ST_IDLE; // [RULE14]
					susp_q <= 1'h0;
				end else if ((st_q == ST_IDLE) && pend_q) begin
					st_q <= ST_BODY; // [RULE16]
					xmit_q <= 1'h1;
					pos_q <= 7'h00;
					same_q <= 3'h0;
					last_q <= `CFSL_RECESSIVE;
					can_tx <= `CFSL_DOMINANT;
					ovl_q <= 2'h0;
				end
			end
			ST_BODY: begin
				pos_q <= pos_n;
				same_q <= same_n;
				last_q <= rx_s_q;
				if (!stuff_now) begin
					dbit <= rx_s_q;
					dbit_en <= 1'h1;
					if ((pos_q != 7'h00) && (pos_q < `CFSL_POS_RTR)) begin
						rx_id <= {rx_id[9:0], rx_s_q}; // [RULE23]
					end else if (pos_q == `CFSL_POS_RTR) begin
						rx_rtr <= rx_s_q;
					end else if ((pos_q >= `CFSL_POS_DLC) && (pos_q < `CFSL_HDR_BITS)) begin
						rx_dlc <= {rx_dlc[2:0], rx_s_q};
					end else if ((pos_q >= `CFSL_HDR_BITS)
						&& (pos_q < `CFSL_HDR_BITS + data_len(rx_rtr, rx_dlc))) begin
						rx_data <= {rx_data[62:0], rx_s_q}; // [RULE1]
					end
				end
				if (lose_c) begin
					xmit_q <= 1'h0; // [RULE17]
					arb_lost <= 1'h1;
					can_tx <= `CFSL_RECESSIVE;
				end else if (body_end) begin
					st_q <= ST_CRCD; // [RULE22]
					can_tx <= `CFSL_RECESSIVE;
				end else if (xmit_q) begin
					can_tx <= body_tx; // [RULE20] [RULE22]
				end
			end
			ST_CRCD: begin
				st_q <= ST_ACKS;
				// Receivers with a good CRC pull the slot dominant
				can_tx <= xmit_q | crc_bad;
			end
			ST_ACKS: begin
				st_q <= ST_ACKD;
				can_tx <= `CFSL_RECESSIVE;
			end
			ST_ACKD: begin
				st_q <= ST_EOF;
				cnt_q <= 7'h00;
			end
			ST_EOF: begin
				cnt_q <= cnt_q + 7'h01;
				if (cnt_q == `CFSL_EOF_BITS - 7'h01) begin
					st_q <= ST_INTER;
					cnt_q <= 7'h00;
					if (xmit_q) begin
						xmit_q <= 1'h0;
						pend_q <= tx_req;
						tx_done <= 1'h1;
						susp_q <= 1'h1;
					end else begin
						rx_valid <= 1'h1;
					end
				end
			end
			ST_INTER: begin
				cnt_q <= cnt_q + 7'h01;
				if (!rx_s_q && ((cnt_q == `CFSL_INTER_BITS - 7'h01) || (ovl_q == `CFSL_MAX_OVL))) begin
					// Last intermission bit dominant, or overloads used up
					st_q <= ST_BODY; // [RULE11]
					pos_q <= 7'h01;
					same_q <= 3'h1;
					last_q <= `CFSL_DOMINANT;
					ovl_q <= 2'h0;
					susp_q <= 1'h0;
				end else if (!rx_s_q) begin
					// Overload reaction only; never raised on our own
					st_q <= ST_OFLAG; // [RULE10] [RULE11]
					cnt_q <= 7'h00;
					can_tx <= `CFSL_DOMINANT; // [RULE13]
					ovl_q <= ovl_q + 2'h1;
					ovl_evt <= 1'h1;
				end else if (cnt_q == `CFSL_INTER_BITS - 7'h01) begin
					// No start is possible before this point
					cnt_q <= 7'h00; // [RULE15] [RULE7]
					st_q <= (susp_q && err_passive) ? ST_SUSP : ST_IDLE; // [RULE14]
					susp_q <= susp_q && err_passive;
				end
			end
			ST_EFLAG, ST_OFLAG: begin
				cnt_q <= cnt_n;
				last_q <= rx_s_q;
				if (cnt_n == `CFSL_FLAG_BITS) begin
					st_q <= ST_WAIT; // [RULE3] [RULE4] [RULE13]
					can_tx <= `CFSL_RECESSIVE;
				end
			end
			ST_WAIT: begin
				// First recessive bit counts as delimiter bit one
				if (rx_s_q) begin
					st_q <= ST_DELIM; // [RULE6] [RULE13]
					cnt_q <= 7'h01;
				end
			end
			ST_DELIM: begin
				cnt_q <= cnt_q + 7'h01;
				if (cnt_q == `CFSL_DELIM_BITS - 7'h01) begin
					st_q <= ST_INTER; // [RULE6] [RULE7] [RULE12]
					cnt_q <= 7'h00;
				end
			end
			default: begin
				st_q <= ST_IDLE;
			end
			endcase
		end
	end
end

endmodule
`default_nettype wire

// ==== cfsl_frame_assertions.sv ====
// Purpose: port-level protocol checks for cfsl_frame
// Assumes: bit ticks are several clocks apart
// Notes: the flag counter follows dominant flags only
`timescale 1ns/100ps
`default_nettype none
module cfsl_chk (
	input wire clock,
	input wire rstn,
	input wire bit_tick,
	input wire can_tx,
	input wire err_passive,
	input wire tx_done,
	input wire tx_retry,
	input wire arb_lost,
	input wire rx_valid,
	input wire err_evt,
	input wire ovl_evt,
	input wire bus_idle
);
	logic [2:0] fcnt_q;
	logic [1:0] novl_q;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);
	////////////////////////////////////////
	// Bits of a dominant flag so far; a fresh flag restarts the count
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) fcnt_q <= 3'h6;
		else if (ovl_evt || (err_evt && !err_passive)) fcnt_q <= 3'h0;
		else if (err_evt) fcnt_q <= 3'h6;
		else if (bit_tick && fcnt_q != 3'h6) fcnt_q <= fcnt_q + 3'h1;
	end
	// Overloads since the last frame end; cleared generously so only a third one can fire
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) novl_q <= 2'h0;
		else if (tx_done || rx_valid || err_evt || bus_idle) novl_q <= 2'h0;
		else if (ovl_evt && novl_q != 2'h3) novl_q <= novl_q + 2'h1;
	end
	a_tx_nrz_hold: assert property (!$past(bit_tick) |-> $stable(can_tx))
		else $error("can_tx moved without a bit tick");
	a_flag_six_dom: assert property (fcnt_q < 3'h6 |-> !can_tx)
		else $error("dominant flag cut short");
	a_flag_next_bit: assert property ((err_evt && !err_passive) || ovl_evt |-> !can_tx)
		else $error("flag did not start at once");
	a_passive_flag: assert property (err_evt && err_passive |-> can_tx[*4])
		else $error("passive flag not recessive");
	a_retry_on_err: assert property (tx_retry |-> err_evt)
		else $error("retry without an error");
	a_ovl_no_retry: assert property (ovl_evt |-> !tx_retry && !err_evt)
		else $error("overload caused a retry");
	a_ovl_two_max: assert property (ovl_evt |-> novl_q < 2'h2)
		else $error("third overload frame");
	a_arb_drop_tx: assert property (arb_lost |-> can_tx ##1 can_tx)
		else $error("driving after lost arbitration");
	a_idle_recessive: assert property (bus_idle |-> can_tx)
		else $error("dominant drive in bus idle");
	c_two_ovl: cover property (ovl_evt ##[1:400] ovl_evt);
	c_arb: cover property (arb_lost);
	c_passive: cover property (err_evt && err_passive);
endmodule
bind cfsl_frame cfsl_chk u_cfsl_chk (.clock, .rstn, .bit_tick, .can_tx, .err_passive, .tx_done,
	.tx_retry, .arb_lost, .rx_valid, .err_evt, .ovl_evt, .bus_idle);
`default_nettype wire

// ==== cfsl_peer.sv ====
// Purpose: another node on the shared bus that jams dominant bits
// Assumes: bus is the wired level, sampled at each bit tick
// Notes: jams on a frame start, or after eight recessive bits when armed
`timescale 1ns/100ps
`default_nettype none
module cfsl_peer (
	input wire logic clock,
	input wire logic rstn,
	input wire logic bit_tick,
	input wire logic bus,
	input wire logic arm_ovl,
	input wire logic arm_sof,
	output logic peer_tx
);
	logic [3:0] run_q;
	logic [2:0] jam_q;
	// Recessive run and a seven-bit dominant burst, moved only at bit ticks
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			run_q <= 4'h0;
			jam_q <= 3'h0;
		end else if (bit_tick) begin
			run_q <= !bus ? 4'h0 : (run_q == 4'hf) ? run_q : run_q + 4'h1;
			if (jam_q != 3'h0) jam_q <= jam_q - 3'h1;
			else if (arm_ovl && bus && run_q == 4'h7) jam_q <= 3'h7;
			else if (arm_sof && !bus && run_q != 4'h0) jam_q <= 3'h7;
		end
	end
	// Released line goes recessive, the level the bus rests at
	assign peer_tx = (jam_q == 3'h0);
endmodule
`default_nettype wire

// ==== cfsl_frame_tb_top.sv ====
// Purpose: self-checking bench for cfsl_frame against a jamming peer
// Assumes: a bit tick every eight clocks; nobody acknowledges frames
// Notes: each scenario resets first, since pending retries never end
`timescale 1ns/100ps
`default_nettype none
module cfsl_frame_tb_top;
	logic clock = 1'b0, rstn = 1'b0, bit_tick = 1'b0, err_passive = 1'b0;
	logic tx_req = 1'b0, tx_rtr = 1'b0, arm_ovl = 1'b0, arm_sof = 1'b0;
	logic [10:0] tx_id = 11'h000;
	logic [2:0] div_q = 3'h0;
	wire can_tx, peer_tx, err_evt, ovl_evt, tx_retry, arb_lost, bus_idle;
	wire [2:0] err_code;
	wire can_rx = can_tx & peer_tx; // Wired-AND: dominant wins
	int miscompares = 0, n_tests = 0, cyc = 0, n_err = 0, n_ovl = 0, n_rty = 0, n_arb = 0;
	cfsl_frame u_cfsl_frame (.clock, .rstn, .bit_tick, .can_rx, .can_tx, .err_passive, .tx_req,
		.tx_id, .tx_rtr, .tx_dlc(4'h1), // Same DLC for remote and data frames
		.tx_data(64'hffff_ffff_ffff_ffff), .tx_crc(15'h0000),
		.crc_bad(1'h0), .tx_done(), .tx_retry, .arb_lost, .rx_valid(), .rx_id(), .rx_rtr(),
		.rx_dlc(), .rx_data(), .dbit(), .dbit_en(), .hard_sync(), .err_evt, .err_code,
		.ovl_evt, .bus_idle);
	cfsl_peer u_cfsl_peer (.clock, .rstn, .bit_tick, .bus(can_rx), .arm_ovl, .arm_sof, .peer_tx);
	////////////////////////////////////////
	always #5 clock = ~clock;
	// Bit ticks, pulse counts and the hang limit
	always @(posedge clock) begin
		div_q <= div_q + 3'h1;
		bit_tick <= #1 (div_q == 3'h7);
		cyc++;
		if (err_evt === 1'b1) n_err++;
		if (ovl_evt === 1'b1) n_ovl++;
		if (tx_retry === 1'b1) n_rty++;
		if (arb_lost === 1'b1) n_arb++;
		if (cyc == 20000) begin
			miscompares++;
			tally_and_finish();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Settle three clocks after the next tick, so can_tx shows the bit now on the wire
	task automatic nxt;
		@(posedge clock iff bit_tick);
		repeat (3) @(posedge clock);
		#1;
	endtask
	task automatic run(input int n, input logic v);
		repeat (n) begin
			chk(can_tx, v);
			nxt();
		end
	endtask
	task automatic upto(ref int c, input int k);
		repeat (3000) begin
			if (c >= k) break;
			@(posedge clock);
			#1;
		end
		chk(c >= k, 1);
	endtask
	task automatic boot(input logic pas);
		rstn = 1'b0;
		err_passive = pas;
		repeat (3) @(posedge clock);
		#1;
		rstn = 1'b1;
		chk(bus_idle, 1'b1);
		n_err = 0;
		n_ovl = 0;
		n_rty = 0;
		n_arb = 0;
	endtask
	task automatic req;
		tx_req = 1'b1;
		@(posedge clock);
		#1;
		tx_req = 1'b0;
	endtask
	////////////////////////////////////////
	// Remote frame of id zero: stuffing, then ack error and error frame spacing
	task automatic sc_remote;
		logic [27:0] exp = 28'h04120c1;
		boot(1'b0);
		tx_rtr = 1'b1;
		req();
		nxt();
		for (int i = 27; i >= 0; i--) begin
			chk(can_tx, exp[i]);
			nxt();
		end
		upto(n_err, 1);
		chk(err_code, 3'h4);
		run(6, 1'b0);
		run(11, 1'b1);
		if (can_tx !== 1'b0) nxt();
		chk(can_tx, 1'b0);
		chk(bus_idle, 1'b0);
		chk(n_rty, 1);
	endtask
	task automatic sc_passive;
		boot(1'b1);
		tx_rtr = 1'b0;
		tx_id = 11'h2a5;
		req();
		upto(n_err, 1);
		run(6, 1'b1);
	endtask
	// Peer keeps hitting intermission: two overloads, then a frame start
	task automatic sc_overload;
		boot(1'b0);
		tx_id = 11'h0f0;
		req();
		upto(n_err, 1);
		arm_ovl = 1'b1;
		upto(n_err, 2);
		arm_ovl = 1'b0;
		chk(n_ovl, 2);
		chk(n_rty, 1);
		chk(err_code, 3'h2);
	endtask
	task automatic sc_arbit;
		boot(1'b0);
		arm_sof = 1'b1;
		tx_id = 11'h555;
		req();
		upto(n_arb, 1);
		arm_sof = 1'b0;
		chk(can_tx, 1'b1);
		upto(n_err, 1);
		chk(err_code, 3'h2);
		chk(n_rty, 0);
	endtask
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		sc_remote();
		sc_passive();
		sc_overload();
		sc_arbit();
		tally_and_finish();
	end
endmodule
`default_nettype wire
